/* include/wff_map.svh */
// Register map, field positions, reset values and constants of the wake-frame filter bank
`ifndef WFF_MAP_SVH
`define WFF_MAP_SVH

`define WFF_PG_BASE 2'h0
`define WFF_PG_RB 2'h2
`define WFF_PG_CFG 2'h3

`define WFF_OFS_BMASK0 4'h1
`define WFF_OFS_BMASK3 4'h4
`define WFF_OFS_CRC_LO 4'h5
`define WFF_OFS_CRC_HI 4'h6
`define WFF_OFS_START 4'h7
`define WFF_OFS_LASTB 4'h8
`define WFF_OFS_CMD 4'h9
`define WFF_OFS_WAKE_CSR 4'hA
`define WFF_OFS_INT_STAT 4'h0
`define WFF_OFS_INT_MASK 4'h0
`define WFF_OFS_DATA_CFG 4'hE
`define WFF_OFS_INTR_MASK 4'hF

`define WFF_CSR_FLAG_BIT 5
`define WFF_CSR_EN_BIT 1
`define WFF_INT_MATCH_BIT 0
`define WFF_INT_COMMIT_BIT 1

`define WFF_CMD_EN_BIT 0
`define WFF_CMD_DA_BIT 1
`define WFF_CMD_MC_BIT 2
`define WFF_CMD_CSCD_LSB 16
`define WFF_CMD_KEEP 32'h000F7777
`define WFF_WORD_RESET 32'h00000000
`define WFF_BYTE_RESET 8'h00

`define WFF_CRC_POLY_REFL 16'hA001
`define WFF_CRC_INIT 16'hFFFF
`define WFF_LAST_LANE 2'h3
`define WFF_IDX_MAX 11'h7FF

`endif

/* include/wff_pkg.sv */
// Types shared by the wake-frame filter bank
package wff_pkg;
   typedef logic [31:0] wff_word_t;
   typedef logic [7:0] wff_byte_t;
   typedef logic [15:0] wff_crc_t;
   typedef enum logic {WFF_IDLE, WFF_FRAME} wff_state_t;
endpackage

/* src/wff_filter_bank.sv */
// Wake-frame filter configuration bank with frame matcher, readback copies and event interrupt
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "wff_map.svh"

module wff_filter_bank
   import wff_pkg::*;
#(
   parameter int NUM_FILT = 4
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] page_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic pmr_write_i,
   input wire logic rx_valid_i,
   input wire logic rx_sof_i,
   input wire logic rx_eof_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_da_hit_i,
   input wire logic rx_mcast_i,
   output logic [7:0] rdata_o,
   output logic [7:0] data_config_o,
   output logic [7:0] intr_mask_o,
   output logic [3:0] filter_match_o,
   output logic wake_o,
   output logic irq_o
);

   // One CRC step per byte, LSB first with the reflected generator
   function automatic wff_crc_t crc_step(input wff_crc_t c, input wff_byte_t d);
      wff_crc_t r;
      r = c;
      for (int b = 0; b < 8; b++) begin
         if (r[0] ^ d[b]) begin
            r = (r >> 1) ^ `WFF_CRC_POLY_REFL;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   // Register state
   wff_word_t bmask [NUM_FILT];
   wff_word_t crc_lo, crc_hi, start_ofs, last_bytes, cmd, stage;
   logic [1:0] lane;
   logic [3:0] seq_ofs;
   logic seq_live;
   logic [7:0] data_config, intr_mask;
   logic wake_en, wake_flag;
   logic [1:0] int_stat, int_mask;

   wff_word_t next_bmask [NUM_FILT];
   wff_word_t next_crc_lo, next_crc_hi, next_start_ofs, next_last_bytes, next_cmd, next_stage;
   logic [1:0] next_lane;
   logic [3:0] next_seq_ofs;
   logic next_seq_live;
   logic [7:0] next_data_config, next_intr_mask, next_rdata;
   logic next_wake_en, next_wake_flag, next_irq, next_wake;
   logic [1:0] next_int_stat, next_int_mask;

   // Matcher state
   wff_state_t mstate, next_mstate;
   logic [10:0] bidx, next_bidx;
   wff_crc_t fcrc [NUM_FILT];
   wff_crc_t next_fcrc [NUM_FILT];
   wff_byte_t flast [NUM_FILT];
   wff_byte_t next_flast [NUM_FILT];
   logic [3:0] raw_hit, fin_hit, next_match;
   logic match_any;

   logic cfg_acc, cfg_word, wr_word, rd_word, commit;
   logic [2:0] cscd;
   wff_word_t word_sel;

   assign cfg_acc = page_i == `WFF_PG_CFG;
   assign cfg_word = cfg_acc && addr_i >= `WFF_OFS_BMASK0 && addr_i <= `WFF_OFS_CMD;
   assign wr_word = wr_i && cfg_word;
   assign rd_word = rd_i && cfg_word;
   // Taken from the registered lane so the commit strobe does not loop back through the next-state logic
   assign commit = wr_word && seq_live && seq_ofs == addr_i && lane == `WFF_LAST_LANE;
   assign cscd = cmd[`WFF_CMD_CSCD_LSB +: 3];
   assign match_any = |fin_hit;

   always_comb begin
      case (addr_i)
         4'h1: word_sel = bmask[0];
         4'h2: word_sel = bmask[1];
         4'h3: word_sel = bmask[2];
         4'h4: word_sel = bmask[3];
         `WFF_OFS_CRC_LO: word_sel = crc_lo;
         `WFF_OFS_CRC_HI: word_sel = crc_hi;
         `WFF_OFS_START: word_sel = start_ofs;
         `WFF_OFS_LASTB: word_sel = last_bytes;
         `WFF_OFS_CMD: word_sel = cmd;
         default: word_sel = `WFF_WORD_RESET;
      endcase
   end

   // Register file: byte-lane sequencing, commits, readback, flags
   always_comb begin
      next_bmask = bmask;
      next_crc_lo = crc_lo;
      next_crc_hi = crc_hi;
      next_start_ofs = start_ofs;
      next_last_bytes = last_bytes;
      next_cmd = cmd;
      next_stage = stage;
      next_lane = lane;
      next_seq_ofs = seq_ofs;
      next_seq_live = seq_live;
      next_data_config = data_config;
      next_intr_mask = intr_mask;
      next_wake_en = wake_en;
      next_wake_flag = wake_flag;
      next_int_stat = int_stat;
      next_int_mask = int_mask;
      next_rdata = `WFF_BYTE_RESET;
      // A sequence restarts at lane 0 when the offset changes; reads and writes count alike
      if (wr_word || rd_word) begin
         if (!seq_live || seq_ofs != addr_i) begin
            next_lane = 2'h1;
            next_seq_ofs = addr_i;
            next_seq_live = 1'b1;
         end else begin
            next_lane = lane + 2'h1;
         end
      end
      if (wr_word) begin
         if (!seq_live || seq_ofs != addr_i) begin
            next_stage[7:0] = wdata_i;
         end else begin
            next_stage[lane*8 +: 8] = wdata_i;
         end
      end
      // Whole word lands at once so the matcher never sees a half-loaded value
      if (commit) begin
         case (addr_i)
            4'h1: next_bmask[0] = {wdata_i, stage[23:0]};
            4'h2: next_bmask[1] = {wdata_i, stage[23:0]};
            4'h3: next_bmask[2] = {wdata_i, stage[23:0]};
            4'h4: next_bmask[3] = {wdata_i, stage[23:0]};
            `WFF_OFS_CRC_LO: next_crc_lo = {wdata_i, stage[23:0]};
            `WFF_OFS_CRC_HI: next_crc_hi = {wdata_i, stage[23:0]};
            `WFF_OFS_START: next_start_ofs = {wdata_i, stage[23:0]};
            `WFF_OFS_LASTB: next_last_bytes = {wdata_i, stage[23:0]};
            `WFF_OFS_CMD: next_cmd = {wdata_i, stage[23:0]} & `WFF_CMD_KEEP;
            default: next_stage = stage;
         endcase
      end
      if (wr_i && page_i == `WFF_PG_BASE && addr_i == `WFF_OFS_DATA_CFG) begin
         next_data_config = wdata_i;
      end
      if (wr_i && page_i == `WFF_PG_BASE && addr_i == `WFF_OFS_INTR_MASK) begin
         next_intr_mask = wdata_i;
      end
      if (wr_i && cfg_acc && addr_i == `WFF_OFS_WAKE_CSR) begin
         next_wake_en = wdata_i[`WFF_CSR_EN_BIT];
         if (wdata_i[`WFF_CSR_FLAG_BIT]) begin
            next_wake_flag = 1'b0;
         end
      end
      if (pmr_write_i) begin
         next_wake_flag = 1'b0;
      end
      if (wr_i && cfg_acc && addr_i == `WFF_OFS_INT_STAT) begin
         next_int_stat = int_stat & ~wdata_i[1:0];
      end
      if (wr_i && page_i == `WFF_PG_RB && addr_i == `WFF_OFS_INT_MASK) begin
         next_int_mask = wdata_i[1:0];
      end
      // Hardware sets win over a clear in the same cycle
      if (match_any) begin
         next_wake_flag = 1'b1;
         next_int_stat[`WFF_INT_MATCH_BIT] = 1'b1;
      end
      if (commit) begin
         next_int_stat[`WFF_INT_COMMIT_BIT] = 1'b1;
      end
      if (rd_i) begin
         if (rd_word) begin
            if (!seq_live || seq_ofs != addr_i) begin
               next_rdata = word_sel[7:0];
            end else begin
               next_rdata = word_sel[lane*8 +: 8];
            end
         end else if (page_i == `WFF_PG_RB && addr_i == `WFF_OFS_DATA_CFG) begin
            next_rdata = data_config;
         end else if (page_i == `WFF_PG_RB && addr_i == `WFF_OFS_INTR_MASK) begin
            next_rdata = intr_mask;
         end else if (page_i == `WFF_PG_BASE && addr_i == `WFF_OFS_DATA_CFG) begin
            next_rdata = data_config;
         end else if (page_i == `WFF_PG_BASE && addr_i == `WFF_OFS_INTR_MASK) begin
            next_rdata = intr_mask;
         end else if (cfg_acc && addr_i == `WFF_OFS_WAKE_CSR) begin
            next_rdata = 8'h00;
            next_rdata[`WFF_CSR_FLAG_BIT] = wake_flag;
            next_rdata[`WFF_CSR_EN_BIT] = wake_en;
         end else if (cfg_acc && addr_i == `WFF_OFS_INT_STAT) begin
            next_rdata = {6'h00, int_stat};
         end else if (page_i == `WFF_PG_RB && addr_i == `WFF_OFS_INT_MASK) begin
            next_rdata = {6'h00, int_mask};
         end
      end
      next_irq = |(next_int_stat & next_int_mask);
      next_wake = next_wake_flag && next_wake_en;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_FILT; i++) begin
            bmask[i] <= `WFF_WORD_RESET;
         end
         crc_lo <= `WFF_WORD_RESET;
         crc_hi <= `WFF_WORD_RESET;
         start_ofs <= `WFF_WORD_RESET;
         last_bytes <= `WFF_WORD_RESET;
         cmd <= `WFF_WORD_RESET;
         stage <= `WFF_WORD_RESET;
         lane <= 2'h0;
         seq_ofs <= 4'h0;
         seq_live <= 1'b0;
         data_config <= `WFF_BYTE_RESET;
         intr_mask <= `WFF_BYTE_RESET;
         wake_en <= 1'b0;
         wake_flag <= 1'b0;
         int_stat <= 2'h0;
         int_mask <= 2'h0;
         rdata_o <= `WFF_BYTE_RESET;
         data_config_o <= `WFF_BYTE_RESET;
         intr_mask_o <= `WFF_BYTE_RESET;
         irq_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         bmask <= next_bmask;
         crc_lo <= next_crc_lo;
         crc_hi <= next_crc_hi;
         start_ofs <= next_start_ofs;
         last_bytes <= next_last_bytes;
         cmd <= next_cmd;
         stage <= next_stage;
         lane <= next_lane;
         seq_ofs <= next_seq_ofs;
         seq_live <= next_seq_live;
         data_config <= next_data_config;
         intr_mask <= next_intr_mask;
         wake_en <= next_wake_en;
         wake_flag <= next_wake_flag;
         int_stat <= next_int_stat;
         int_mask <= next_int_mask;
         rdata_o <= next_rdata;
         data_config_o <= next_data_config;
         intr_mask_o <= next_intr_mask;
         irq_o <= next_irq;
         wake_o <= next_wake;
      end
   end

   // Frame matcher: one CRC engine per filter over the masked window
   always_comb begin
      next_mstate = mstate;
      next_bidx = bidx;
      if (rx_valid_i) begin
         if (rx_sof_i) begin
            next_bidx = 11'h001;
            next_mstate = WFF_FRAME;
         end else if (bidx != `WFF_IDX_MAX) begin
            next_bidx = bidx + 11'h001;
         end
         if (rx_eof_i) begin
            next_mstate = WFF_IDLE;
         end
      end
   end

   generate
      for (genvar f = 0; f < NUM_FILT; f++) begin : g_filt
         logic [10:0] idx, base, rel;
         logic [7:0] fofs;
         logic [15:0] want;
         logic sel;
         assign idx = rx_sof_i ? 11'h000 : bidx;
         assign fofs = start_ofs[f*8 +: 8];
         assign base = {2'b00, fofs, 1'b0};
         assign rel = idx - base;
         assign sel = rx_valid_i && (rx_sof_i || mstate == WFF_FRAME) && idx >= base && rel < 11'd32
            && bmask[f][rel[4:0]];
         assign want = (f < 2) ? crc_lo[(f%2)*16 +: 16] : crc_hi[(f%2)*16 +: 16];
         always_comb begin
            next_fcrc[f] = rx_valid_i && rx_sof_i ? `WFF_CRC_INIT : fcrc[f];
            next_flast[f] = rx_valid_i && rx_sof_i ? `WFF_BYTE_RESET : flast[f];
            if (sel) begin
               next_fcrc[f] = crc_step(next_fcrc[f], rx_data_i);
               next_flast[f] = rx_data_i;
            end
            raw_hit[f] = rx_valid_i && rx_eof_i && cmd[f*4 + `WFF_CMD_EN_BIT] && next_fcrc[f] == want
               && next_flast[f] == last_bytes[f*8 +: 8] && (!cmd[f*4 + `WFF_CMD_DA_BIT] || rx_da_hit_i)
               && (!cmd[f*4 + `WFF_CMD_MC_BIT] || rx_mcast_i);
         end
         always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
               fcrc[f] <= `WFF_CRC_INIT;
               flast[f] <= `WFF_BYTE_RESET;
            end else begin
               fcrc[f] <= next_fcrc[f];
               flast[f] <= next_flast[f];
            end
         end
      end
   endgenerate

   // A cascade link drops a filter's hit unless the neighbour on that link also has a raw hit
   always_comb begin
      for (int f = 0; f < NUM_FILT; f++) begin
         fin_hit[f] = raw_hit[f];
         if (f > 0 && cscd[f-1] && !raw_hit[f-1]) begin
            fin_hit[f] = 1'b0;
         end
         if (f < NUM_FILT - 1 && cscd[f] && !raw_hit[f+1]) begin
            fin_hit[f] = 1'b0;
         end
      end
      next_match = fin_hit;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         mstate <= WFF_IDLE;
         bidx <= 11'h000;
         filter_match_o <= 4'h0;
      end else begin
         mstate <= next_mstate;
         bidx <= next_bidx;
         filter_match_o <= next_match;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   data_cfg_readback_a: assert property (rd_i && page_i == `WFF_PG_RB && addr_i == `WFF_OFS_DATA_CFG
      |=> rdata_o == $past(data_config))
      else $error("data config readback wrong");
   intr_mask_readback_a: assert property (rd_i && page_i == `WFF_PG_RB && addr_i == `WFF_OFS_INTR_MASK
      |=> rdata_o == $past(intr_mask))
      else $error("interrupt mask readback wrong");
   rb_read_only_a: assert property (wr_i && page_i == `WFF_PG_RB && addr_i == `WFF_OFS_DATA_CFG
      |=> $stable(data_config))
      else $error("readback page altered data config");
   mask_commit_a: assert property (wr_i && page_i == `WFF_PG_CFG && addr_i == 4'h2 && seq_live
      && seq_ofs == 4'h2 && lane == `WFF_LAST_LANE |=> bmask[1] == {$past(wdata_i), $past(stage[23:0])})
      else $error("mask word not assembled");
   lane_wrap_a: assert property (wr_word && seq_live && seq_ofs == addr_i && lane == `WFF_LAST_LANE
      |=> lane == 2'h0)
      else $error("lane did not wrap");
   no_early_commit_a: assert property (wr_word && (!seq_live || seq_ofs != addr_i)
      |=> $stable(cmd) && lane == 2'h1)
      else $error("word changed on first byte");
   cmd_reserved_a: assert property ((cmd & ~`WFF_CMD_KEEP) == 32'h00000000)
      else $error("reserved command bits set");
   reset_zero_a: assert property (@(posedge mclk_i) disable iff (1'b0) !rst_n_i |=> cmd == 32'h00000000
      && start_ofs == 32'h00000000 && bmask[0] == 32'h00000000)
      else $error("config not zero after reset");
   flag_set_a: assert property (match_any |=> wake_flag && filter_match_o != 4'h0)
      else $error("match did not set flag");
   flag_clear_a: assert property (pmr_write_i && !match_any |=> !wake_flag)
      else $error("flag not cleared by power write");
   wake_gate_a: assert property (wake_o == (wake_en && wake_flag))
      else $error("wake without enable");
   disabled_filter_a: assert property (filter_match_o[0] |-> $past(cmd[`WFF_CMD_EN_BIT]))
      else $error("disabled filter matched");
   irq_level_a: assert property (irq_o == |(int_stat & int_mask))
      else $error("irq level wrong");

   commit_seen_c: cover property (commit && addr_i == `WFF_OFS_CMD);
   match_seen_c: cover property (match_any ##1 wake_flag);
   cascade_seen_c: cover property (fin_hit[0] && cscd[0]);
   wake_seen_c: cover property (wake_o ##1 irq_o);

endmodule

/* tb/wff_filter_bank_tb.sv */
// Self-checking testbench of the wake-frame filter bank
`timescale 1ns/10ps

module wff_filter_bank_tb;
   import wff_pkg::*;
   logic mclk, rst_n, pmr_write, rx_valid, rx_sof, rx_eof, rx_da_hit, rx_mcast;
   logic [1:0] page;
   logic [3:0] addr, fmatch;
   logic [7:0] wdata, rx_data, rdata, data_config, intr_mask;
   logic wr, rd, wake, irq;
   int failures = 0;
   int compares = 0;

   wff_filter_bank uut (.mclk_i(mclk), .rst_n_i(rst_n), .page_i(page), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .pmr_write_i(pmr_write), .rx_valid_i(rx_valid), .rx_sof_i(rx_sof),
      .rx_eof_i(rx_eof), .rx_data_i(rx_data), .rx_da_hit_i(rx_da_hit), .rx_mcast_i(rx_mcast),
      .rdata_o(rdata), .data_config_o(data_config), .intr_mask_o(intr_mask),
      .filter_match_o(fmatch), .wake_o(wake), .irq_o(irq));
   wff_host_model host (.mclk_i(mclk), .rdata_i(rdata), .page_o(page), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));

   always #4 mclk = ~mclk;

   task automatic stop_test();
      if (failures == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
      chk_word({28'h0, got}, {28'h0, exp});
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask

   function automatic logic [7:0] fr(input int i);
      return 8'(17 * (i + 1));
   endfunction

   function automatic logic [31:0] word_of(input int o);
      return 32'hD0C0B0A0 + 32'h01010101 * o;
   endfunction

   // Reflected form of x^16 + x^15 + x^2 + 1, shifted out LSB first
   function automatic logic [15:0] crc_over(input int first, input int last);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = first; i <= last; i++) begin
         c = c ^ {8'h00, fr(i)};
         for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction

   task automatic send_frame(input int bad, input logic da, input logic mc, input logic [3:0] exp);
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         rx_valid <= 1'b1;
         rx_sof <= (i == 0);
         rx_eof <= (i == 7);
         rx_data <= (i == bad) ? 8'hEE : fr(i);
         rx_da_hit <= da;
         rx_mcast <= mc;
      end
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_eof <= 1'b0;
      rx_data <= 8'h5A;
      #1 chk_nib(fmatch, exp);
      @(posedge mclk);
      #1 chk_nib(fmatch, 4'h0);
   endtask

   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
   endtask

   task automatic t_reset();
      logic [31:0] w;
      logic [7:0] b;
      for (int o = 1; o <= 9; o++) begin
         host.read_word(4'(o), w);
         chk_word(w, 32'h00000000);
      end
      host.rd_byte(2'h2, 4'hE, b);
      chk_word({24'h0, b}, 32'h00000000);
      chk_bit(irq, 1'b0);
      chk_bit(wake, 1'b0);
   endtask

   task automatic t_words();
      logic [31:0] w;
      logic [7:0] b;
      for (int o = 1; o <= 8; o++) host.write_word(4'(o), word_of(o));
      for (int o = 1; o <= 8; o++) begin
         host.read_word(4'(o), w);
         chk_word(w, word_of(o));
      end
      host.rd_byte(2'h3, 4'h0, b);
      chk_word({24'h0, b}, 32'h00000002);
      host.write_word(4'h9, 32'hFFFFFFFF);
      host.read_word(4'h9, w);
      chk_word(w, 32'h000F7777);
      // Three writes only: the word must stay as it was
      for (int i = 0; i < 3; i++) host.wr_byte(2'h3, 4'h1, 8'h00);
      host.read_word(4'h2, w);
      chk_word(w, word_of(2));
      host.read_word(4'h1, w);
      chk_word(w, word_of(1));
   endtask

   task automatic t_readback();
      logic [7:0] b;
      host.wr_byte(2'h0, 4'hE, 8'hA5);
      host.wr_byte(2'h0, 4'hF, 8'h3C);
      host.wr_byte(2'h2, 4'hE, 8'h00);
      host.wr_byte(2'h2, 4'hF, 8'h00);
      host.rd_byte(2'h2, 4'hE, b);
      chk_word({24'h0, b}, 32'h000000A5);
      host.rd_byte(2'h2, 4'hF, b);
      chk_word({24'h0, b}, 32'h0000003C);
      // Read data stands for one cycle only
      @(posedge mclk);
      #1 chk_word({24'h0, rdata}, 32'h00000000);
      chk_word({24'h0, data_config}, 32'h000000A5);
      chk_word({24'h0, intr_mask}, 32'h0000003C);
      host.rd_byte(2'h3, 4'hC, b);
      chk_word({24'h0, b}, 32'h00000000);
   endtask

   task automatic t_frames();
      logic [31:0] cmds [9] = '{32'h11, 32'h11, 32'h13, 32'h13, 32'h15, 32'h15, 32'h20011, 32'h10011, 32'h10011};
      int bads [9] = '{-1, 0, -1, -1, -1, -1, -1, -1, 0};
      logic [8:0] das = 9'b000001000;
      logic [8:0] mcs = 9'b000100000;
      logic [3:0] exps [9] = '{4'h3, 4'h2, 4'h2, 4'h3, 4'h2, 4'h3, 4'h1, 4'h3, 4'h0};
      host.write_word(4'h1, 32'h0000000F);
      host.write_word(4'h2, 32'h00000003);
      host.write_word(4'h5, {crc_over(2, 3), crc_over(0, 3)});
      host.write_word(4'h7, 32'h00000100);
      host.write_word(4'h8, 32'h00004444);
      for (int k = 0; k < 9; k++) begin
         host.write_word(4'h9, cmds[k]);
         send_frame(bads[k], das[k], mcs[k], exps[k]);
      end
   endtask

   task automatic t_events();
      chk_bit(wake, 1'b0);
      host.wr_byte(2'h3, 4'hA, 8'h02);
      settle();
      chk_bit(wake, 1'b1);
      @(posedge mclk);
      pmr_write <= 1'b1;
      @(posedge mclk);
      pmr_write <= 1'b0;
      settle();
      chk_bit(wake, 1'b0);
      send_frame(-1, 1'b0, 1'b0, 4'h3);
      chk_bit(wake, 1'b1);
      host.wr_byte(2'h3, 4'hA, 8'h22);
      settle();
      chk_bit(wake, 1'b0);
      host.wr_byte(2'h2, 4'h0, 8'h01);
      settle();
      chk_bit(irq, 1'b1);
      host.wr_byte(2'h3, 4'h0, 8'h01);
      settle();
      chk_bit(irq, 1'b0);
      host.wr_byte(2'h2, 4'h0, 8'h03);
      settle();
      chk_bit(irq, 1'b1);
      host.wr_byte(2'h3, 4'h0, 8'h03);
      settle();
      chk_bit(irq, 1'b0);
   endtask

   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      pmr_write = 1'b0;
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      rx_eof = 1'b0;
      rx_data = 8'h00;
      rx_da_hit = 1'b0;
      rx_mcast = 1'b0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_words();
      t_readback();
      t_frames();
      t_events();
      stop_test();
   end

   // Whole run is about 500 cycles; this margin only cuts a hang
   initial begin
      #200000;
      failures++;
      stop_test();
   end
endmodule

/* tb/wff_host_model.sv */
// Host processor model driving the byte-wide register port of the filter bank
`timescale 1ns/10ps

module wff_host_model (
   input wire logic mclk_i,
   input wire logic [7:0] rdata_i,
   output logic [1:0] page_o,
   output logic [3:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   initial begin
      page_o = 2'h0;
      addr_o = 4'h0;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   task automatic wr_byte(input logic [1:0] pg, input logic [3:0] ad, input logic [7:0] d);
      @(posedge mclk_i);
      page_o <= pg;
      addr_o <= ad;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge mclk_i);
      wr_o <= 1'b0;
      // Released data lines must not keep showing the last value
      wdata_o <= ~d;
   endtask

   task automatic rd_byte(input logic [1:0] pg, input logic [3:0] ad, output logic [7:0] d);
      @(posedge mclk_i);
      page_o <= pg;
      addr_o <= ad;
      rd_o <= 1'b1;
      @(posedge mclk_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
   endtask

   // Low byte first, same offset four times in a row
   task automatic write_word(input logic [3:0] ad, input logic [31:0] w);
      for (int i = 0; i < 4; i++) wr_byte(2'h3, ad, w[8*i+:8]);
   endtask

   task automatic read_word(input logic [3:0] ad, output logic [31:0] w);
      for (int i = 0; i < 4; i++) rd_byte(2'h3, ad, w[8*i+:8]);
   endtask
endmodule
